// File: hw/alu_core.v
// combinational result and carry of one accumulator operation
`timescale 1ns/10ps
`include "alu_regs.vh"

module alu_core (
    input wire [2:0] op,
    input wire [3:0] acc,
    input wire [3:0] operand,
    output reg [3:0] result,
    output reg carry
);

    // for table forms operand bit 3 is the fetched bit 7 or bit 3, already selected
    always @* begin
        result = acc;
        carry = 1'b0;
        case (op)
            `ALU_OP_AND: begin
                result = acc & operand;
                carry = acc[3] & operand[3];
            end
            `ALU_OP_OR: begin
                result = acc | operand;
                carry = 1'b0;
            end
            `ALU_OP_XOR: begin
                result = acc ^ operand;
                carry = acc[3] & operand[3];
            end
            `ALU_OP_INC: begin
                result = acc + 4'h1;
                // nonzero result clears carry; only a wrap sets it
                carry = (acc == 4'hF);
            end
            `ALU_OP_ROT: begin
                result = {acc[2:0], acc[3]};
                carry = acc[3];
            end
            default: begin
                result = acc;
                carry = 1'b0;
            end
        endcase
    end

endmodule

// File: hw/alu_regs.vh
// constants for the accumulator logic unit
`ifndef ALU_REGS_VH
`define ALU_REGS_VH

// program word widths and the assembler expansion
`define ALU_WORD_W 10
`define ALU_ASM_W 16
`define ALU_EXT_BITS 3'h7

// operation group, bits 9-6 of the 10-bit word
`define ALU_GRP_AND 4'hD
`define ALU_GRP_OR 4'hE
`define ALU_GRP_XOR 4'hA

// operand form, bits 4-0 of the 10-bit word
`define ALU_FORM_IND 5'h10
`define ALU_FORM_IMM 5'h11

// single-operand words, whole 10-bit codes
`define ALU_W_INC 10'h293
`define ALU_W_ROT 10'h393
`define ALU_W_ROTZ 10'h3D3

// internal operation codes for the core
`define ALU_OP_AND 3'h0
`define ALU_OP_OR 3'h1
`define ALU_OP_XOR 3'h2
`define ALU_OP_INC 3'h3
`define ALU_OP_ROT 3'h4

// nibble read port selectors
`define ALU_RD_GP_LO 2'h0
`define ALU_RD_GP_HI 2'h1
`define ALU_RD_PORT 2'h2
`define ALU_RD_TIMER 2'h3

// reset values
`define ALU_ACC_RST 4'h0
`define ALU_CY_RST 1'b0
`define ALU_GP_RST 4'h0
`define ALU_PORT_RST 4'hF

`endif

// File: hw/alu_unit.v
// accumulator logic unit: decode, operand select, register storage
//
// Behaviour
// - Decoder takes 10-bit program words.
// - 16-bit assembler words lose their two 111 groups to become 10 bits.
// - No instruction runs during reset or stop mode.
// - Port pairs 0, 1, 3, 4 hold a 4-bit low and 4-bit high nibble.
// - Timer is read as a low and a high 4-bit part.
// - Two 16-entry nibble banks; a pair joins equal indices.
// - AND register into accumulator; carry is both bit 3s ANDed.
// - AND table nibble high or low; carry from bit 3 and bit 7/3.
// - Two-word AND immediate; carry from both bit 3s.
// - OR register into accumulator; carry cleared.
// - OR table nibble high or low; carry cleared.
// - Two-word OR immediate; carry cleared.
// - XOR register into accumulator; carry from both bit 3s.
// - XOR table nibble high or low; carry from bit 3 and bit 7/3.
// - Two-word XOR immediate; carry from both bit 3s.
// - Increment accumulator; carry set on wrap to zero.
// - Rotate accumulator left, bit 3 to bit 0 and to carry.
// - Rotate-or-reset: zero accumulator requests device reset, else rotate.
`timescale 1ns/10ps
`include "alu_regs.vh"

module alu_unit #(
    parameter PAGE_W = 4,
    parameter TIMER_W = 8
) (
    input wire clk,
    input wire rst_n,
    input wire stop_mode,
    input wire instr_valid,
    input wire [9:0] instr_word,
    input wire [15:0] asm_word,
    input wire asm_sel,
    input wire [PAGE_W-1:0] table_page_register,
    input wire [9:0] rom_data,
    input wire gp_wr_en,
    input wire gp_wr_high,
    input wire [3:0] gp_wr_index,
    input wire [3:0] gp_wr_data,
    input wire port_wr_en,
    input wire port_wr_high,
    input wire [2:0] port_wr_index,
    input wire [3:0] port_wr_data,
    input wire [TIMER_W-1:0] timer_value,
    input wire [1:0] rd_kind,
    input wire [3:0] rd_index,
    input wire rd_high,
    output reg instr_ready,
    output reg [3:0] acc,
    output reg carry_flag,
    output reg [PAGE_W+7:0] tbl_addr,
    output reg op_done,
    output reg reset_req,
    output reg asm_error,
    output reg foreign_op,
    output reg [3:0] rd_data
);

    // sequencer states
    localparam ST_DECODE = 2'h0;
    localparam ST_IMM = 2'h1;
    localparam ST_FETCH = 2'h2;
    localparam ST_EXEC = 2'h3;

    // 10-bit word from the 16-bit assembler form
    function [9:0] asm_compress;
        input [15:0] a;
        begin
            asm_compress = {a[12:8], a[4:0]};
        end
    endfunction

    // both inserted groups must read 111
    function asm_ext_ok;
        input [15:0] a;
        begin
            asm_ext_ok = (a[15:13] == `ALU_EXT_BITS) &&
                         (a[7:5] == `ALU_EXT_BITS);
        end
    endfunction

    // operation group to core operation code
    function [2:0] grp_op;
        input [3:0] g;
        begin
            case (g)
                `ALU_GRP_AND: grp_op = `ALU_OP_AND;
                `ALU_GRP_OR: grp_op = `ALU_OP_OR;
                default: grp_op = `ALU_OP_XOR;
            endcase
        end
    endfunction

    // port index 0, 1, 3, 4 to storage slot; invalid index gives slot 4
    function [2:0] port_slot;
        input [3:0] n;
        begin
            case (n)
                4'h0: port_slot = 3'h0;
                4'h1: port_slot = 3'h1;
                4'h3: port_slot = 3'h2;
                4'h4: port_slot = 3'h3;
                default: port_slot = 3'h4;
            endcase
        end
    endfunction

    // nibble storage: general banks and port register pairs
    reg [3:0] gp_low_bank [0:15];
    reg [3:0] gp_high_bank [0:15];
    reg [3:0] port_low_nibble [0:3];
    reg [3:0] port_high_nibble [0:3];

    reg [1:0] state;
    reg [1:0] next_state;
    reg [2:0] pend_op;
    reg [2:0] next_pend_op;
    reg pend_low;
    reg next_pend_low;
    reg [3:0] pend_operand;
    reg [3:0] next_pend_operand;
    reg next_ready;

    // decode signals of the accepted word
    wire take;
    wire [9:0] word;
    wire word_ok;
    wire [3:0] grp;
    wire bank_low;
    wire [4:0] form;
    wire is_logic;
    wire [7:0] table_pointer;
    wire [2:0] wr_slot;
    wire [2:0] rd_slot;

    // core operands and results
    reg [2:0] core_op;
    reg [3:0] core_operand;
    reg core_go;
    reg core_rotz;
    wire [3:0] core_result;
    wire core_carry;

    assign take = instr_valid && instr_ready && !stop_mode;
    assign word = asm_sel ? asm_compress(asm_word) : instr_word;
    assign word_ok = !asm_sel || asm_ext_ok(asm_word);
    assign grp = word[9:6];
    assign bank_low = word[5];
    assign form = word[4:0];
    assign is_logic = (grp == `ALU_GRP_AND) || (grp == `ALU_GRP_OR) ||
                      (grp == `ALU_GRP_XOR);
    // pointer pairs high-bank and low-bank entry 0
    assign table_pointer = {gp_high_bank[0], gp_low_bank[0]};
    assign wr_slot = port_slot({1'b0, port_wr_index});
    assign rd_slot = port_slot(rd_index);

    alu_core u_core (
        .op(core_op),
        .acc(acc),
        .operand(core_operand),
        .result(core_result),
        .carry(core_carry)
    );

    // decode and sequencing; immediate and table forms take a second step
    always @* begin
        next_state = state;
        next_pend_op = pend_op;
        next_pend_low = pend_low;
        next_pend_operand = pend_operand;
        next_ready = instr_ready;
        core_op = `ALU_OP_AND;
        core_operand = 4'h0;
        core_go = 1'b0;
        core_rotz = 1'b0;
        case (state)
            ST_DECODE: begin
                next_ready = !stop_mode;
                if (take && word_ok) begin
                    if (word == `ALU_W_INC) begin
                        core_op = `ALU_OP_INC;
                        core_go = 1'b1;
                    end else if (word == `ALU_W_ROT) begin
                        core_op = `ALU_OP_ROT;
                        core_go = 1'b1;
                    end else if (word == `ALU_W_ROTZ) begin
                        core_op = `ALU_OP_ROT;
                        core_go = 1'b1;
                        core_rotz = 1'b1;
                    end else if (is_logic && !form[4]) begin
                        // register form, bit 5 picks the low bank
                        core_op = grp_op(grp);
                        core_operand = bank_low ? gp_low_bank[form[3:0]] :
                                       gp_high_bank[form[3:0]];
                        core_go = 1'b1;
                    end else if (is_logic && form == `ALU_FORM_IND) begin
                        // table read needs a cycle for the program memory
                        next_pend_op = grp_op(grp);
                        next_pend_low = bank_low;
                        next_state = ST_FETCH;
                        next_ready = 1'b0;
                    end else if (is_logic && bank_low &&
                                 form == `ALU_FORM_IMM) begin
                        next_pend_op = grp_op(grp);
                        next_state = ST_IMM;
                    end
                end
            end
            ST_IMM: begin
                // second word carries the immediate in its low nibble
                next_ready = !stop_mode;
                if (take) begin
                    core_op = pend_op;
                    core_operand = word[3:0];
                    core_go = 1'b1;
                    next_state = ST_DECODE;
                end
            end
            ST_FETCH: begin
                next_ready = 1'b0;
                next_state = ST_EXEC;
            end
            ST_EXEC: begin
                // bits 7-4 or 3-0 of the fetched word
                core_op = pend_op;
                next_pend_operand = pend_low ? rom_data[3:0] :
                                    rom_data[7:4];
                core_operand = next_pend_operand;
                core_go = !stop_mode;
                if (!stop_mode) begin
                    next_state = ST_DECODE;
                    next_ready = 1'b1;
                end
            end
            default: begin
                next_state = ST_DECODE;
                next_ready = 1'b0;
            end
        endcase
    end

    // sequencer and accumulator; stop mode holds acc and carry, but a table fetch still moves from fetch to its execute state
    always @(posedge clk) begin
        if (!rst_n) begin
            state <= ST_DECODE;
            pend_op <= `ALU_OP_AND;
            pend_low <= 1'b0;
            pend_operand <= 4'h0;
            instr_ready <= 1'b0;
            acc <= `ALU_ACC_RST;
            carry_flag <= `ALU_CY_RST;
            tbl_addr <= {(PAGE_W+8){1'b0}};
            op_done <= 1'b0;
            reset_req <= 1'b0;
            asm_error <= 1'b0;
            foreign_op <= 1'b0;
        end else begin
            state <= next_state;
            pend_op <= next_pend_op;
            pend_low <= next_pend_low;
            pend_operand <= next_pend_operand;
            instr_ready <= next_ready;
            op_done <= core_go && !(core_rotz && acc == 4'h0);
            asm_error <= take && !word_ok;
            // words of other groups are left to their own units
            foreign_op <= take && word_ok && state == ST_DECODE &&
                          next_state == ST_DECODE && !core_go;
            // page register and pointer address the table word
            if (state == ST_DECODE && next_state == ST_FETCH) begin
                tbl_addr <= {table_page_register, table_pointer};
            end
            if (core_rotz && acc == 4'h0) begin
                // zero accumulator: ask for a full reset, no rotate
                reset_req <= 1'b1;
            end else begin
                reset_req <= 1'b0;
            end
            if (core_go && !(core_rotz && acc == 4'h0)) begin
                acc <= core_result;
                carry_flag <= core_carry;
            end
        end
    end

    // general register and port storage, written by other groups
    integer i;
    always @(posedge clk) begin
        if (!rst_n) begin
            for (i = 0; i < 16; i = i + 1) begin
                gp_low_bank[i] <= `ALU_GP_RST;
                gp_high_bank[i] <= `ALU_GP_RST;
            end
            for (i = 0; i < 4; i = i + 1) begin
                port_low_nibble[i] <= `ALU_PORT_RST;
                port_high_nibble[i] <= `ALU_PORT_RST;
            end
        end else begin
            if (gp_wr_en) begin
                if (gp_wr_high) begin
                    gp_high_bank[gp_wr_index] <= gp_wr_data;
                end else begin
                    gp_low_bank[gp_wr_index] <= gp_wr_data;
                end
            end
            // writes to a missing port index are dropped
            if (port_wr_en && wr_slot != 3'h4) begin
                if (port_wr_high) begin
                    port_high_nibble[wr_slot[1:0]] <= port_wr_data;
                end else begin
                    port_low_nibble[wr_slot[1:0]] <= port_wr_data;
                end
            end
        end
    end

    // nibble read port, one cycle behind the select
    always @(posedge clk) begin
        if (!rst_n) begin
            rd_data <= 4'h0;
        end else begin
            case (rd_kind)
                `ALU_RD_GP_LO: rd_data <= gp_low_bank[rd_index];
                `ALU_RD_GP_HI: rd_data <= gp_high_bank[rd_index];
                `ALU_RD_PORT: begin
                    if (rd_slot == 3'h4) begin
                        rd_data <= 4'h0;
                    end else if (rd_high) begin
                        rd_data <= port_high_nibble[rd_slot[1:0]];
                    end else begin
                        rd_data <= port_low_nibble[rd_slot[1:0]];
                    end
                end
                `ALU_RD_TIMER: begin
                    // low part bits 3-0, high part bits 7-4
                    rd_data <= rd_high ? timer_value[7:4] :
                               timer_value[3:0];
                end
                default: rd_data <= 4'h0;
            endcase
        end
    end

endmodule

// File: testbench/alu_unit_bench.sv
// self-checking bench for the accumulator logic unit
`timescale 1ns/10ps
`include "alu_regs.vh"

module alu_unit_bench;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg stop_mode = 1'b0;
    reg instr_valid = 1'b0;
    reg [9:0] instr_word = 10'h000;
    reg [15:0] asm_word = 16'hFFFF;
    reg asm_sel = 1'b0;
    reg [3:0] page = 4'h0;
    reg [9:0] rom_data = 10'h000;
    reg gp_wr_en = 1'b0;
    reg gp_wr_high = 1'b0;
    reg [3:0] gp_wr_index = 4'h0;
    reg [3:0] gp_wr_data = 4'h0;
    reg [1:0] rd_kind = 2'h0;
    reg [3:0] rd_index = 4'h0;
    reg rd_high = 1'b0;
    reg port_wr_en = 1'b0;
    reg port_wr_high = 1'b0;
    reg [2:0] port_wr_index = 3'h0;
    reg [3:0] port_wr_data = 4'h0;
    wire instr_ready, carry_flag, op_done, reset_req, asm_error, foreign_op;
    wire [3:0] acc;
    wire [3:0] rd_data;
    wire [11:0] tbl_addr;
    reg [3:0] lo [0:15];
    reg [3:0] hi [0:15];
    reg [3:0] m_acc = 4'h0;
    reg [15:0] bad = 16'h0000;
    integer n_mismatch = 0;
    integer comparisons = 0;

    alu_unit u_dut (
        .clk(clk), .rst_n(rst_n), .stop_mode(stop_mode),
        .instr_valid(instr_valid), .instr_word(instr_word),
        .asm_word(asm_word), .asm_sel(asm_sel),
        .table_page_register(page), .rom_data(rom_data),
        .gp_wr_en(gp_wr_en), .gp_wr_high(gp_wr_high),
        .gp_wr_index(gp_wr_index), .gp_wr_data(gp_wr_data),
        .port_wr_en(port_wr_en), .port_wr_high(port_wr_high),
        .port_wr_index(port_wr_index), .port_wr_data(port_wr_data),
        .timer_value(8'hA5),
        .rd_kind(rd_kind), .rd_index(rd_index), .rd_high(rd_high),
        .instr_ready(instr_ready), .acc(acc), .carry_flag(carry_flag),
        .tbl_addr(tbl_addr), .op_done(op_done), .reset_req(reset_req),
        .asm_error(asm_error), .foreign_op(foreign_op), .rd_data(rd_data)
    );

    always #25 clk = ~clk;

    // synchronous program memory: answers one edge after the address
    always @(posedge clk) rom_data <= {2'h3, ~tbl_addr[7:0]};

    task chk(input string nm, input [11:0] e, input [11:0] g);
        begin
            comparisons = comparisons + 1;
            if (g !== e) begin
                n_mismatch = n_mismatch + 1;
                $display("[ERR] %s expected %h seen %h", nm, e, g);
            end
        end
    endtask

    // expected {carry, acc} from the model accumulator
    function [4:0] ref_op(input [9:0] w, input [3:0] o);
        begin
            if (w == `ALU_W_INC)
                ref_op = {m_acc == 4'hF, m_acc + 4'h1};
            else if (w == `ALU_W_ROT || w == `ALU_W_ROTZ)
                ref_op = {m_acc[3], m_acc[2:0], m_acc[3]};
            else if (w[9:6] == `ALU_GRP_OR)
                ref_op = {1'b0, m_acc | o};
            else if (w[9:6] == `ALU_GRP_AND)
                ref_op = {m_acc[3] & o[3], m_acc & o};
            else
                ref_op = {m_acc[3] & o[3], m_acc ^ o};
        end
    endfunction

    // offers a word in both forms; returns at the edge that takes it
    task send(input [9:0] w);
        integer n;
        begin
            instr_word <= w;
            asm_word <= {3'h7, w[9:5], 3'h7, w[4:0]} ^ bad;
            n = 0;
            @(posedge clk);
            while (instr_ready !== 1'b1 && n < 20) begin
                n = n + 1;
                @(posedge clk);
            end
        end
    endtask

    task run(input [9:0] w, input [3:0] o, input two);
        reg [4:0] e;
        integer n;
        begin
            e = ref_op(w, o);
            instr_valid <= 1'b1;
            send(w);
            if (two)
                send({6'h00, o});
            instr_valid <= 1'b0;
            n = 0;
            @(negedge clk);
            while (op_done !== 1'b1 && n < 5) begin
                n = n + 1;
                @(negedge clk);
            end
            chk("op_done", 1, op_done);
            chk("acc", e[3:0], acc);
            chk("carry_flag", e[4], carry_flag);
            m_acc = e[3:0];
            @(posedge clk);
        end
    endtask

    task wr(input h, input [3:0] i, input [3:0] d);
        begin
            gp_wr_en <= 1'b1;
            gp_wr_high <= h;
            gp_wr_index <= i;
            gp_wr_data <= d;
            if (h)
                hi[i] = d;
            else
                lo[i] = d;
            @(posedge clk);
            gp_wr_en <= 1'b0;
            @(posedge clk);
        end
    endtask

    task rd(input [1:0] k, input [3:0] i, input h, input [3:0] e);
        begin
            rd_kind <= k;
            rd_index <= i;
            rd_high <= h;
            @(posedge clk);
            @(negedge clk);
            chk("rd_data", e, rd_data);
            @(posedge clk);
        end
    endtask

    // garbled increment must not run, else acc would read 1
    task t_asm;
        begin
            asm_sel <= 1'b1;
            bad = 16'h4000;
            instr_valid <= 1'b1;
            send(`ALU_W_INC);
            instr_valid <= 1'b0;
            @(negedge clk);
            chk("asm_error", 1, asm_error);
            chk("op_done", 0, op_done);
            chk("acc", 0, acc);
            bad = 16'h0000;
            @(posedge clk);
            // a word of another group is taken and ignored
            instr_valid <= 1'b1;
            send(10'h3E5);
            instr_valid <= 1'b0;
            @(negedge clk);
            chk("foreign_op", 1, foreign_op);
            chk("acc", 0, acc);
            @(posedge clk);
            $display("test asm done");
        end
    endtask

    task t_reset;
        begin
            rd(2'h2, 4'h4, 1'b1, 4'hF);
            rd(2'h0, 4'h7, 1'b0, 4'h0);
            rd(2'h3, 4'h0, 1'b1, 4'hA);
            rd(2'h3, 4'h0, 1'b0, 4'h5);
            // high nibble of pair 3 written; its low half must keep F
            port_wr_en <= 1'b1;
            port_wr_high <= 1'b1;
            port_wr_index <= 3'h3;
            port_wr_data <= 4'h6;
            @(posedge clk);
            port_wr_en <= 1'b0;
            rd(2'h2, 4'h3, 1'b1, 4'h6);
            rd(2'h2, 4'h3, 1'b0, 4'hF);
            $display("test reset done");
        end
    endtask

    // register forms through the assembler path
    task t_reg;
        reg [59:0] ws;
        reg [9:0] w;
        reg [3:0] o;
        integer k;
        begin
            wr(1'b0, 4'h5, 4'hC);
            wr(1'b1, 4'h5, 4'h9);
            rd(2'h1, 4'h5, 1'b0, 4'h9);
            run(10'h3B1, 4'hA, 1'b1);
            ws = {10'h365, 10'h285, 10'h3A5, 10'h345, 10'h385, 10'h2A5};
            for (k = 5; k >= 0; k = k - 1) begin
                w = ws[10*k +: 10];
                o = w[5] ? lo[w[3:0]] : hi[w[3:0]];
                run(w, o, 1'b0);
            end
            $display("test reg done");
        end
    endtask

    task t_imm;
        begin
            asm_sel <= 1'b0;
            run(10'h3B1, 4'hF, 1'b1);
            run(10'h371, 4'hA, 1'b1);
            run(10'h2B1, 4'h3, 1'b1);
            run(10'h2B1, 4'hA, 1'b1);
            $display("test imm done");
        end
    endtask

    // pointer 63 on page 5; memory holds 9C there
    task t_table;
        reg [59:0] ws;
        reg [9:0] w;
        integer k;
        begin
            wr(1'b0, 4'h0, 4'h3);
            wr(1'b1, 4'h0, 4'h6);
            page <= 4'h5;
            ws = {10'h350, 10'h370, 10'h390, 10'h3B0, 10'h290, 10'h2B0};
            for (k = 5; k >= 0; k = k - 1) begin
                w = ws[10*k +: 10];
                run(w, w[5] ? 4'hC : 4'h9, 1'b0);
                chk("tbl_addr", 12'h563, tbl_addr);
            end
            $display("test table done");
        end
    endtask

    task t_single;
        begin
            run(10'h3B1, 4'hF, 1'b1);
            run(`ALU_W_INC, 4'h0, 1'b0);
            run(`ALU_W_INC, 4'h0, 1'b0);
            run(`ALU_W_ROT, 4'h0, 1'b0);
            run(10'h3B1, 4'h8, 1'b1);
            run(`ALU_W_ROT, 4'h0, 1'b0);
            run(`ALU_W_ROTZ, 4'h0, 1'b0);
            run(`ALU_W_ROTZ, 4'h0, 1'b0);
            run(10'h371, 4'h0, 1'b1);
            instr_valid <= 1'b1;
            send(`ALU_W_ROTZ);
            instr_valid <= 1'b0;
            @(negedge clk);
            chk("reset_req", 1, reset_req);
            chk("acc", 0, acc);
            @(posedge clk);
            $display("test single done");
        end
    endtask

    // a word offered during stop must wait until stop ends
    task t_stop;
        begin
            stop_mode <= 1'b1;
            instr_word <= `ALU_W_INC;
            instr_valid <= 1'b1;
            repeat (4) @(posedge clk);
            @(negedge clk);
            chk("instr_ready", 0, instr_ready);
            chk("acc", m_acc, acc);
            @(posedge clk);
            stop_mode <= 1'b0;
            run(`ALU_W_INC, 4'h0, 1'b0);
            $display("test stop done");
        end
    endtask

    task summarize;
        begin
            $display("comparisons %0d mismatches %0d",
                     comparisons, n_mismatch);
            if (n_mismatch == 0 && comparisons > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask

    // watchdog: the tests need well under a thousand cycles
    initial begin
        #(50 * 5000);
        n_mismatch = n_mismatch + 1;
        summarize;
    end

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_asm;
        t_reset;
        t_reg;
        t_imm;
        t_table;
        t_single;
        t_stop;
        summarize;
    end
endmodule

// File: testbench/alu_unit_chk.sv
// assertion checker bound to the accumulator logic unit
`timescale 1ns/10ps
`include "alu_regs.vh"

module alu_unit_chk #(
    parameter PAGE_W = 4
) (
    input wire clk,
    input wire rst_n,
    input wire stop_mode,
    input wire instr_valid,
    input wire [9:0] instr_word,
    input wire [15:0] asm_word,
    input wire asm_sel,
    input wire [PAGE_W-1:0] table_page_register,
    input wire instr_ready,
    input wire [3:0] acc,
    input wire carry_flag,
    input wire [PAGE_W+7:0] tbl_addr,
    input wire op_done,
    input wire reset_req,
    input wire asm_error
);
    // word as the decoder sees it, from either input form
    wire [9:0] w = asm_sel ? {asm_word[12:8], asm_word[4:0]} : instr_word;
    wire take = instr_valid && instr_ready && !stop_mode;
    wire grp = w[9:6] == `ALU_GRP_AND || w[9:6] == `ALU_GRP_OR ||
        w[9:6] == `ALU_GRP_XOR;
    wire tbl = take && grp && w[4:0] == `ALU_FORM_IND;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_ready_release: assert property (
        $rose(rst_n) |-> !instr_ready)
        else $error("word offered at reset release");
    a_stop_ready: assert property (
        stop_mode |=> !instr_ready)
        else $error("ready while stopped");
    a_stop_hold: assert property (
        stop_mode |=> $stable(acc))
        else $error("accumulator moved while stopped");
    a_done_cause: assert property (
        op_done |-> $past(take) || $past(take, 3))
        else $error("op done without a taken word");
    a_table_gap: assert property (
        tbl |=> !instr_ready [*2] ##1 op_done)
        else $error("table fetch timing wrong");
    a_table_page: assert property (tbl |=>
        tbl_addr[PAGE_W+7:8] == $past(table_page_register))
        else $error("table page not on address");
    a_imm_wait: assert property (
        take && grp && w[4:0] == `ALU_FORM_IMM |=> !op_done)
        else $error("immediate form done after one word");
    a_inc_wrap: assert property (
        take && w == `ALU_W_INC && acc == 4'hF |=> acc == 4'h0 && carry_flag)
        else $error("increment wrap wrong");
    a_rot_move: assert property (
        take && w == `ALU_W_ROT |=> acc == {$past(acc[2:0]), $past(acc[3])}
        && carry_flag == $past(acc[3]))
        else $error("rotate result wrong");
    a_rotz_zero: assert property (
        take && w == `ALU_W_ROTZ && acc == 4'h0 |=> reset_req && acc == 4'h0)
        else $error("zero rotate did not request reset");
    a_asm_bad: assert property (take && asm_sel &&
        (asm_word[15:13] != 3'h7 || asm_word[7:5] != 3'h7) |=> asm_error)
        else $error("bad assembler word not flagged");
    a_or_clear: assert property (
        take && w[9:6] == `ALU_GRP_OR && !w[4] |=> !carry_flag && op_done)
        else $error("register or left carry set");
endmodule

bind alu_unit alu_unit_chk #(.PAGE_W(PAGE_W)) u_chk (
    .clk(clk), .rst_n(rst_n), .stop_mode(stop_mode),
    .instr_valid(instr_valid), .instr_word(instr_word),
    .asm_word(asm_word), .asm_sel(asm_sel),
    .table_page_register(table_page_register),
    .instr_ready(instr_ready), .acc(acc), .carry_flag(carry_flag),
    .tbl_addr(tbl_addr), .op_done(op_done), .reset_req(reset_req),
    .asm_error(asm_error)
);
